// ==== hw/serial_flash_program_link_consts.svh ====
// constants for the serial programming link
// How it works
// - program mode needs select and boot pins high
// - clock pin high selects mode 1, low mode 2
// - mode 1 uses clock, in, out, busy
// - mode 2 leaves data in and out idle (out held high) and uses only the busy pin
// - bytes of eight bits, lsb first
// - mode 1 samples input on rising clock
// - mode 1 changes output on falling clock
// - busy low when ready, high at reception
// - busy high while transferring, erasing, programming
// - commands rejected until seven-byte id matches, unless flash is blank
// - only user rom area may be rewritten
// - mode 2 busy pin shows boot check
`ifndef SERIAL_FLASH_PROGRAM_LINK_CONSTS_SVH
`define SERIAL_FLASH_PROGRAM_LINK_CONSTS_SVH
`define BYTE_BITS      8
`define BIT_CNT_W      4
`define ID_LEN         7
`define ID_IDX_W       3
`define TXD_IDLE       1'b1
`define BUSY_RESET     1'b1
`define BIT_CNT_RESET  4'h0
`define BYTE_RESET     8'h00
`endif

// ==== hw/serial_flash_program_link_pkg.sv ====
// types shared by the serial programming link
package serial_flash_program_link_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic {ID_WAIT, ID_OK} id_state_t;
endpackage

// ==== hw/link_shift_if.sv ====
// bundle between link control and bit shifter
`timescale 1ns/10ps
`default_nettype none
interface link_shift_if;
    import serial_flash_program_link_pkg::*;
    logic  enable;
    logic  tx_load;
    byte_t tx_byte;
    logic  tx_active;
    logic  rx_active;
    logic  rx_done;
    byte_t rx_byte;
    logic  txd;
    modport ctrl    (output enable, tx_load, tx_byte,
                     input tx_active, rx_active, rx_done, rx_byte, txd);
    modport shifter (input enable, tx_load, tx_byte,
                     output tx_active, rx_active, rx_done, rx_byte, txd);
endinterface
`default_nettype wire

// ==== hw/link_bit_shifter.sv ====
// clock-synchronous bit shifter for mode 1
`timescale 1ns/10ps
`default_nettype none
`include "serial_flash_program_link_consts.svh"
module link_bit_shifter (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         transfer_clock_pin,
    input  wire logic         serial_data_in,
    link_shift_if.shifter     lk
);
    import serial_flash_program_link_pkg::*;

    logic [1:0]            sclk_meta;
    logic                  sclk_s;
    logic                  sclk_d;
    logic                  rxd_meta;
    logic                  rxd_s;
    logic                  sclk_rise;
    logic                  sclk_fall;
    logic [3:0]            rx_cnt_reg, rx_cnt_next;
    byte_t                 rx_sh_reg, rx_sh_next;
    logic                  rx_done_reg, rx_done_next;
    byte_t                 rx_byte_reg, rx_byte_next;
    logic [3:0]            tx_cnt_reg, tx_cnt_next;
    byte_t                 tx_sh_reg, tx_sh_next;
    logic                  tx_act_reg, tx_act_next;
    logic                  txd_reg, txd_next;

    // two flops before any logic sees the pins
    always_ff @(posedge clk) begin
        sclk_meta <= {sclk_meta[0], transfer_clock_pin};
        rxd_meta  <= serial_data_in;
        rxd_s     <= rxd_meta;
        sclk_d    <= sclk_s;
    end
    assign sclk_s    = sclk_meta[1];
    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;

    always_comb begin
        rx_cnt_next  = rx_cnt_reg;
        rx_sh_next   = rx_sh_reg;
        rx_done_next = 1'b0;
        rx_byte_next = rx_byte_reg;
        tx_cnt_next  = tx_cnt_reg;
        tx_sh_next   = tx_sh_reg;
        tx_act_next  = tx_act_reg;
        txd_next     = txd_reg;
        if (!lk.enable) begin
            rx_cnt_next = `BIT_CNT_RESET;
            tx_cnt_next = `BIT_CNT_RESET;
            tx_act_next = 1'b0;
            txd_next    = `TXD_IDLE;
        end else begin
            if (sclk_rise) begin
                rx_sh_next = {rxd_s, rx_sh_reg[7:1]};
                if (rx_cnt_reg == 4'(`BYTE_BITS - 1)) begin
                    rx_cnt_next  = `BIT_CNT_RESET;
                    rx_done_next = 1'b1;
                    rx_byte_next = {rxd_s, rx_sh_reg[7:1]};
                end else begin
                    rx_cnt_next = rx_cnt_reg + 4'h1;
                end
                if (tx_act_reg && tx_cnt_reg == 4'(`BYTE_BITS))
                    tx_act_next = 1'b0;
            end
            if (lk.tx_load && !tx_act_reg) begin
                tx_sh_next  = lk.tx_byte;
                tx_cnt_next = `BIT_CNT_RESET;
                tx_act_next = 1'b1;
            end else if (sclk_fall && tx_act_reg &&
                         tx_cnt_reg != 4'(`BYTE_BITS)) begin
                txd_next    = tx_sh_reg[0];
                tx_sh_next  = {1'b0, tx_sh_reg[7:1]};
                tx_cnt_next = tx_cnt_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_cnt_reg  <= `BIT_CNT_RESET;
            rx_sh_reg   <= `BYTE_RESET;
            rx_done_reg <= 1'b0;
            rx_byte_reg <= `BYTE_RESET;
            tx_cnt_reg  <= `BIT_CNT_RESET;
            tx_sh_reg   <= `BYTE_RESET;
            tx_act_reg  <= 1'b0;
            txd_reg     <= `TXD_IDLE;
        end else begin
            rx_cnt_reg  <= rx_cnt_next;
            rx_sh_reg   <= rx_sh_next;
            rx_done_reg <= rx_done_next;
            rx_byte_reg <= rx_byte_next;
            tx_cnt_reg  <= tx_cnt_next;
            tx_sh_reg   <= tx_sh_next;
            tx_act_reg  <= tx_act_next;
            txd_reg     <= txd_next;
        end
    end

    assign lk.rx_active = lk.enable && (rx_cnt_reg != `BIT_CNT_RESET);
    assign lk.rx_done   = rx_done_reg;
    assign lk.rx_byte   = rx_byte_reg;
    assign lk.tx_active = tx_act_reg;
    assign lk.txd       = txd_reg;

    a_rx_on_rise: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(rx_done_reg) |-> $past(sclk_rise))
        else $error("byte completed without a rising clock edge");
    a_rx_lsb_first: assert property (
        @(posedge clk) disable iff (!nrst)
        rx_done_reg |-> rx_byte_reg[7] == $past(rxd_s))
        else $error("last sampled bit not in msb position");
    a_rx_eight_bits: assert property (
        @(posedge clk) disable iff (!nrst)
        (lk.enable && sclk_rise && rx_cnt_reg == 4'h7) |=> rx_done_reg)
        else $error("eighth rising edge did not complete a byte");
    a_tx_on_fall: assert property (
        @(posedge clk) disable iff (!nrst)
        (lk.enable && $past(lk.enable) && $changed(txd_reg))
            |-> $past(sclk_fall))
        else $error("data output changed away from falling edge");
    a_idle_high: assert property (
        @(posedge clk) disable iff (!nrst)
        !lk.enable |=> txd_reg)
        else $error("data output not idle high when disabled");
endmodule
`default_nettype wire

// ==== hw/serial_flash_program_link.sv ====
// serial flash programming link, strap decode, id gate and busy
`timescale 1ns/10ps
`default_nettype none
`include "serial_flash_program_link_consts.svh"
module serial_flash_program_link (
    input  wire logic                                   clk,
    input  wire logic                                   nrst,
    input  wire logic                                   boot_mode_pin,
    input  wire logic                                   select_port_pin,
    input  wire logic                                   transfer_clock_pin,
    input  wire logic                                   serial_data_in,
    output var  logic                                   serial_data_out,
    output var  logic                                   busy_output_pin,
    input  wire logic                                   boot_check,
    input  wire logic                                   core_busy,
    input  wire logic                                   flash_blank,
    input  wire logic [55:0]                            id_stored,
    input  wire logic                                   id_byte_valid,
    input  wire serial_flash_program_link_pkg::byte_t   id_byte,
    input  wire logic                                   tx_load,
    input  wire serial_flash_program_link_pkg::byte_t   tx_byte,
    output var  logic                                   tx_ready,
    output var  serial_flash_program_link_pkg::byte_t   rx_byte,
    output var  logic                                   rx_valid,
    output var  logic                                   prog_mode,
    output var  logic                                   sync_mode,
    output var  logic                                   id_verified,
    input  wire logic                                   write_req,
    input  wire logic                                   target_user_rom,
    output var  logic                                   flash_write_en
);
    import serial_flash_program_link_pkg::*;

    logic [2:0]              strap_meta;
    logic [2:0]              strap_sync;
    logic                    strap_done_reg, strap_done_next;
    logic                    prog_reg, prog_next;
    logic                    sync_reg, sync_next;
    id_state_t               id_state_reg, id_state_next;
    logic [`ID_IDX_W-1:0]    id_idx_reg, id_idx_next;
    logic                    id_bad_reg, id_bad_next;
    logic                    busy_reg, busy_next;
    logic                    wen_reg, wen_next;
    logic                    id_hit;

    link_shift_if lk ();

    link_bit_shifter u_shifter (
        .clk                (clk),
        .nrst               (nrst),
        .transfer_clock_pin (transfer_clock_pin),
        .serial_data_in     (serial_data_in),
        .lk                 (lk.shifter)
    );

    function automatic byte_t id_slice(input logic [55:0] code,
                                       input logic [2:0]  idx);
        id_slice = code[{idx, 3'b000} +: 8];
    endfunction

    // strap pins pass two flops; index 0 select, 1 boot, 2 clock
    always_ff @(posedge clk) begin
        strap_meta <= {transfer_clock_pin, boot_mode_pin, select_port_pin};
        strap_sync <= strap_meta;
    end

    assign id_hit = (id_byte == id_slice(id_stored, id_idx_reg));

    always_comb begin
        strap_done_next = strap_done_reg;
        prog_next       = prog_reg;
        sync_next       = sync_reg;
        // levels caught once, on the first edge after reset release
        if (!strap_done_reg) begin
            strap_done_next = 1'b1;
            prog_next = strap_sync[0] & strap_sync[1];
            sync_next = strap_sync[2];
        end
    end

    always_comb begin
        id_state_next = id_state_reg;
        id_idx_next   = id_idx_reg;
        id_bad_next   = id_bad_reg;
        unique case (id_state_reg)
            ID_WAIT: begin
                if (flash_blank) begin
                    id_state_next = ID_OK;
                end else if (id_byte_valid) begin
                    // compare all seven before deciding
                    if (id_idx_reg == 3'(`ID_LEN - 1)) begin
                        id_idx_next = '0;
                        id_bad_next = 1'b0;
                        if (!id_bad_reg && id_hit)
                            id_state_next = ID_OK;
                    end else begin
                        id_idx_next = id_idx_reg + 3'h1;
                        id_bad_next = id_bad_reg | ~id_hit;
                    end
                end
            end
            ID_OK: id_state_next = ID_OK;
        endcase
    end

    always_comb begin
        if (!prog_reg) begin
            busy_next = `BUSY_RESET;
        end else if (sync_reg) begin
            busy_next = lk.rx_active | lk.tx_active | tx_load | core_busy;
        end else begin
            busy_next = boot_check;
        end
        wen_next = prog_reg & (id_state_reg == ID_OK) & write_req
                   & target_user_rom;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            strap_done_reg <= 1'b0;
            prog_reg       <= 1'b0;
            sync_reg       <= 1'b0;
            id_state_reg   <= ID_WAIT;
            id_idx_reg     <= '0;
            id_bad_reg     <= 1'b0;
            busy_reg       <= `BUSY_RESET;
            wen_reg        <= 1'b0;
        end else begin
            strap_done_reg <= strap_done_next;
            prog_reg       <= prog_next;
            sync_reg       <= sync_next;
            id_state_reg   <= id_state_next;
            id_idx_reg     <= id_idx_next;
            id_bad_reg     <= id_bad_next;
            busy_reg       <= busy_next;
            wen_reg        <= wen_next;
        end
    end

    assign lk.enable  = prog_reg & sync_reg;
    assign lk.tx_load = tx_load & tx_ready;
    assign lk.tx_byte = tx_byte;

    assign serial_data_out = lk.txd;
    assign busy_output_pin = busy_reg;
    assign tx_ready        = prog_reg & sync_reg & ~lk.tx_active;
    assign rx_byte         = lk.rx_byte;
    assign rx_valid        = lk.rx_done;
    assign prog_mode       = prog_reg;
    assign sync_mode       = sync_reg;
    assign id_verified     = (id_state_reg == ID_OK);
    assign flash_write_en  = wen_reg;

    a_strap_prog: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(strap_done_reg) |->
            prog_reg == $past(strap_sync[0] & strap_sync[1]))
        else $error("program mode not taken from select and boot straps");
    a_strap_mode: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(strap_done_reg) |-> sync_reg == $past(strap_sync[2]))
        else $error("mode not taken from clock strap");
    a_strap_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        strap_done_reg && $past(strap_done_reg) |->
            $stable(prog_reg) && $stable(sync_reg))
        else $error("strap decode changed after release");
    a_busy_rx: assert property (
        @(posedge clk) disable iff (!nrst)
        (prog_reg && sync_reg && lk.rx_active) |=> busy_reg)
        else $error("busy not high during reception");
    a_busy_work: assert property (
        @(posedge clk) disable iff (!nrst)
        (prog_reg && sync_reg && (core_busy || lk.tx_active)) |=> busy_reg)
        else $error("busy not high while occupied");
    a_busy_ready: assert property (
        @(posedge clk) disable iff (!nrst)
        (prog_reg && sync_reg && !lk.rx_active && !lk.tx_active
         && !tx_load && !core_busy) |=> !busy_reg)
        else $error("busy not low when ready");
    a_busy_check: assert property (
        @(posedge clk) disable iff (!nrst)
        (prog_reg && !sync_reg) |=> busy_reg == $past(boot_check))
        else $error("mode 2 busy pin not showing boot check");
    a_id_gate: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(id_verified) |->
            $past(flash_blank) || ($past(id_byte_valid) && $past(id_hit)
            && !$past(id_bad_reg) && $past(id_idx_reg) == 3'h6))
        else $error("id accepted without seven matching bytes");
    a_id_sticky: assert property (
        @(posedge clk) disable iff (!nrst)
        id_verified |=> id_verified)
        else $error("id acceptance dropped without reset");
    a_id_locked: assert property (
        @(posedge clk) disable iff (!nrst)
        !id_verified |=> !flash_write_en)
        else $error("write enabled before id accepted");
    a_user_rom: assert property (
        @(posedge clk) disable iff (!nrst)
        flash_write_en |-> $past(target_user_rom) && $past(id_verified))
        else $error("write enabled outside user rom or before id");

    // mode 2 keeps the clocked shifter out of the way
    a_mode2_quiet: assert property (
        @(posedge clk) disable iff (!nrst)
        (prog_reg && !sync_reg) |-> !lk.rx_active && !lk.tx_active)
        else $error("shifter active in mode 2");
    a_mode2_txd: assert property (
        @(posedge clk) disable iff (!nrst)
        (prog_reg && !sync_reg) |-> serial_data_out)
        else $error("data output not idle high in mode 2");
    a_tx_in_mode: assert property (
        @(posedge clk) disable iff (!nrst)
        lk.tx_active |-> prog_reg && sync_reg)
        else $error("transmit active outside mode 1");
    a_rx_one_pulse: assert property (
        @(posedge clk) disable iff (!nrst)
        rx_valid |=> !rx_valid)
        else $error("byte complete pulse longer than one cycle");
endmodule
`default_nettype wire

// ==== verification/programmer_model.sv ====
// behavioural serial programmer on the far side of the mode 1 link
`timescale 1ns/10ps
`default_nettype none
module programmer_model (
    input  wire logic clk,
    output var  logic sck,
    output var  logic sdi,
    input  wire logic sdo,
    input  wire logic busy
);
    logic [7:0] got;
    logic       busy_mid;

    initial begin
        sck = 1'b1;
        sdi = 1'b1;
        got = 8'h00;
        busy_mid = 1'b0;
    end

    // clock stands still at the strap level between frames
    task automatic park(input logic lvl);
        sck = lvl;
    endtask

    // one full-duplex byte; wait_rdy off when reading device data and in mode 2
    task automatic xfer(input logic [7:0] d, input logic wait_rdy);
        int n;
        n = 0;
        while (wait_rdy && busy !== 1'b0 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        #1;
        for (int i = 0; i < 8; i++) begin
            sck = 1'b0;
            sdi = d[i];
            #62.5;
            got[i] = sdo;
            sck = 1'b1;
            if (i == 4) begin
                busy_mid = busy;
            end
            #62.5;
        end
        sdi = ~d[7];
    endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the serial programming link
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import serial_flash_program_link_pkg::*;
    logic        clk, nrst, boot_mode_pin, select_port_pin, sck, sdi;
    logic        sdo, busy, boot_check, core_busy, flash_blank;
    logic [55:0] id_stored;
    logic        id_byte_valid, tx_load, tx_ready, rx_valid;
    byte_t       id_byte, tx_byte, rx_byte, last_rx;
    logic        prog_mode, sync_mode, id_verified;
    logic        write_req, target_user_rom, flash_write_en;
    int          num_errors = 0;
    int          tests_run = 0;
    int          rx_count = 0;
    int          base;

    serial_flash_program_link i_serial_flash_program_link (
        .clk(clk), .nrst(nrst), .boot_mode_pin(boot_mode_pin),
        .select_port_pin(select_port_pin), .transfer_clock_pin(sck),
        .serial_data_in(sdi), .serial_data_out(sdo),
        .busy_output_pin(busy), .boot_check(boot_check),
        .core_busy(core_busy), .flash_blank(flash_blank),
        .id_stored(id_stored), .id_byte_valid(id_byte_valid),
        .id_byte(id_byte), .tx_load(tx_load), .tx_byte(tx_byte),
        .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .prog_mode(prog_mode), .sync_mode(sync_mode),
        .id_verified(id_verified), .write_req(write_req),
        .target_user_rom(target_user_rom),
        .flash_write_en(flash_write_en));

    programmer_model i_programmer_model (
        .clk(clk), .sck(sck), .sdi(sdi), .sdo(sdo), .busy(busy));

    initial clk = 1'b0;
    always #4 clk = ~clk;

    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin
            rx_count++;
            last_rx = rx_byte;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic do_reset(input logic b, input logic s, input logic c,
                            input int hold);
        nrst = 1'b0;
        boot_mode_pin = b;
        select_port_pin = s;
        i_programmer_model.park(c);
        tick(hold);
        check("txd_in_reset", sdo, 1'b1);
        check("busy_in_reset", busy, 1'b1);
        nrst = 1'b1;
        tick(4);
    endtask

    task automatic send_id(input logic [55:0] v);
        for (int i = 0; i < 7; i++) begin
            id_byte = v[8*i +: 8];
            id_byte_valid = 1'b1;
            tick(1);
            id_byte_valid = 1'b0;
            tick(1);
        end
        tick(1);
    endtask

    task automatic t_straps;
        check("prog_mode", prog_mode, 1'b1);
        check("sync_mode", sync_mode, 1'b1);
        check("busy_idle", busy, 1'b0);
        $display("test straps done");
    endtask

    task automatic t_rx;
        base = rx_count;
        i_programmer_model.xfer(8'hA5, 1'b1);
        tick(6);
        check("rx_count", rx_count - base, 1);
        check("rx_byte", last_rx, 8'hA5);
        check("busy_rx", i_programmer_model.busy_mid, 1'b1);
        check("busy_after", busy, 1'b0);
        i_programmer_model.xfer(8'h01, 1'b1);
        i_programmer_model.xfer(8'h80, 1'b1);
        tick(6);
        check("rx_count2", rx_count - base, 3);
        check("rx_byte2", last_rx, 8'h80);
        $display("test receive done");
    endtask

    task automatic t_tx;
        check("tx_ready", tx_ready, 1'b1);
        tx_byte = 8'h3C;
        tx_load = 1'b1;
        tick(1);
        tx_load = 1'b0;
        tick(1);
        check("tx_taken", tx_ready, 1'b0);
        check("busy_tx", busy, 1'b1);
        i_programmer_model.xfer(8'hFF, 1'b0);
        tick(6);
        check("tx_data", i_programmer_model.got, 8'h3C);
        check("tx_ready_end", tx_ready, 1'b1);
        $display("test transmit done");
    endtask

    task automatic t_core_busy;
        core_busy = 1'b1;
        tick(3);
        check("busy_core", busy, 1'b1);
        core_busy = 1'b0;
        tick(3);
        check("busy_free", busy, 1'b0);
        $display("test core busy done");
    endtask

    task automatic t_id;
        write_req = 1'b1;
        target_user_rom = 1'b1;
        tick(3);
        check("write_locked", flash_write_en, 1'b0);
        send_id(id_stored ^ 56'h0000_0001_0000_00);
        check("id_bad", id_verified, 1'b0);
        send_id(id_stored);
        check("id_good", id_verified, 1'b1);
        tick(2);
        check("write_user", flash_write_en, 1'b1);
        target_user_rom = 1'b0;
        tick(3);
        check("write_other", flash_write_en, 1'b0);
        write_req = 1'b0;
        $display("test id and write gate done");
    endtask

    task automatic t_mode2;
        do_reset(1'b1, 1'b1, 1'b0, 20);
        check("sync_mode2", sync_mode, 1'b0);
        check("prog_mode2", prog_mode, 1'b1);
        boot_check = 1'b1;
        tick(3);
        check("boot_chk_hi", busy, 1'b1);
        boot_check = 1'b0;
        tick(3);
        check("boot_chk_lo", busy, 1'b0);
        base = rx_count;
        i_programmer_model.xfer(8'h55, 1'b0);
        i_programmer_model.park(1'b0);
        tick(6);
        check("mode2_no_rx", rx_count - base, 0);
        check("mode2_txd", sdo, 1'b1);
        $display("test mode 2 done");
    endtask

    task automatic t_straps_off;
        for (int k = 0; k < 3; k++) begin
            do_reset(k[0], k[1], 1'b1, 20);
            check("prog_off", prog_mode, 1'b0);
        end
        flash_blank = 1'b1;
        do_reset(1'b1, 1'b1, 1'b1, 20);
        check("blank_id", id_verified, 1'b1);
        flash_blank = 1'b0;
        $display("test strap combinations done");
    endtask

    initial begin
        nrst = 1'b0;
        boot_mode_pin = 1'b1;
        select_port_pin = 1'b1;
        boot_check = 1'b0;
        core_busy = 1'b0;
        flash_blank = 1'b0;
        id_stored = 56'h1357_9BDF_2468_AC;
        id_byte_valid = 1'b0;
        id_byte = 8'h00;
        tx_load = 1'b0;
        tx_byte = 8'h00;
        write_req = 1'b0;
        target_user_rom = 1'b0;
        #1;
        do_reset(1'b1, 1'b1, 1'b1, 16);
        t_straps();
        t_rx();
        t_tx();
        t_core_busy();
        t_id();
        t_mode2();
        t_straps_off();
        close_out();
    end

    initial begin
        #200_000;
        num_errors++;
        close_out();
    end
endmodule
`default_nettype wire
